// [logic/iec_regs.vh]
// register offsets, field positions and reset values of the error checker
`ifndef IEC_REGS_VH
`define IEC_REGS_VH
// register byte addresses on the apb bus
`define IEC_OFF_CTRL 12'h000
`define IEC_OFF_FLAGS 12'h004
`define IEC_OFF_FATAL 12'h008
`define IEC_OFF_IRQ_STAT 12'h00c
`define IEC_OFF_IRQ_MASK 12'h010
`define IEC_OFF_TASK_LOG 12'h014
`define IEC_OFF_ADDR_LO 12'h018
`define IEC_OFF_ADDR_HI 12'h01c
// ctrl register fields
`define IEC_CTRL_STOP 0
`define IEC_CTRL_CLEAR 1
`define IEC_CTRL_RST 32'h0000_0000
// flags register fields
`define IEC_FLG_INSTR 0
`define IEC_FLG_ACCESS 1
`define IEC_FLG_EQ 2
`define IEC_FLG_NEG 3
`define IEC_FLG_HALT 4
// fatal flag word bit positions
`define IEC_FAT_INSTR 8
`define IEC_FAT_ACCESS 10
`define IEC_FAT_ILLEGAL 14
`define IEC_FAT_UMOVF 15
// interrupt status bits
`define IEC_IRQ_INSTR 0
`define IEC_IRQ_ACCESS 1
`define IEC_IRQ_FATAL 2
`define IEC_IRQ_W 3
// extended memory limits
`define IEC_EM_MAX_WORD 16'h7fff
// task log encodings
`define IEC_TASK_INT_BASE 16'h8000
`define IEC_TASK_CYC_MAX 8'h1f
`endif

// [logic/iec_sticky.v]
// one sticky event bit with write-one-to-clear, set wins over clear
`timescale 1ns/1ps
module iec_sticky
(
  input wire ref_clk,
  input wire sys_rst,
  input wire set_evt,
  input wire clr_req,
  output reg bit_ff
);
  // set dominates so an event in the clearing cycle is not lost
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      bit_ff <= 1'b0;
    else if (set_evt)
      bit_ff <= 1'b1;
    else if (clr_req)
      bit_ff <= 1'b0;
  end
endmodule // iec_sticky

// [logic/iec_bcd_check.v]
// tells whether a 16-bit word holds four valid bcd digits
`timescale 1ns/1ps
module iec_bcd_check
(
  input wire [15:0] word_in,
  output wire not_bcd
);
  // a nibble above 9 makes the word illegal
  assign not_bcd = (word_in[3:0] > 4'h9) | (word_in[7:4] > 4'h9) |
    (word_in[11:8] > 4'h9) | (word_in[15:12] > 4'h9);
endmodule // iec_bcd_check

// [logic/iec_error_check.v]
// run-time instruction and access error checker with apb registers
// How it works
// - bad operand data suppresses instruction, sets error
// - executing with no active task is error
// - equality/negative flags held or cleared per instruction
// - clean non-input completion clears error flag
// - stop/continue policy, continue after reset
// - stop policy: instruction error halts, sets bit 8
// - five illegal access kinds flag access error
// - access error continues, non-input completion clears error flag
// - direct extended word above 32767 is access error
// - binary indirect pointer 8000..ffff is access error
// - index pointer bit/word kind mismatch is access error
// - stop policy: access error halts, sets bit 10
// - access flag persists across task boundaries
// - undefined opcode fetch always halts, sets bit 14
// - fetch beyond program memory halts, sets bit 15
// - halt logs task number and program address
// - task log cyclic 0000..001f, interrupt 8000..80ff
`timescale 1ns/1ps
`include "iec_regs.vh"
module iec_error_check
#(
  parameter ADDR_W = 32,
  parameter UM_LAST = 32'h0001_ffff
)
(
  input wire ref_clk,
  input wire sys_rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // fetch side from the sequencer
  input wire fetch_valid,
  input wire [ADDR_W-1:0] fetch_addr,
  input wire fetch_opcode_bad,
  // execution side, one pulse per finished instruction
  input wire exec_done,
  input wire exec_is_input,
  input wire task_active,
  input wire task_is_int,
  input wire [7:0] task_num,
  input wire [ADDR_W-1:0] exec_addr,
  input wire operand_bad,
  input wire flags_clear_on_err,
  input wire eq_result,
  input wire neg_result,
  // operand address checks
  input wire acc_param_area,
  input wire acc_write,
  input wire acc_unmounted,
  input wire acc_em_file,
  input wire acc_read_only,
  input wire bcd_indirect,
  input wire [15:0] pointer_word,
  input wire em_direct,
  input wire [15:0] em_word_addr,
  input wire binary_indirect_mode,
  input wire ir_used,
  input wire ir_holds_bit,
  input wire ir_used_as_bit,
  // status outputs
  output reg instr_error_flag,
  output reg access_error_flag,
  output reg equality_flag,
  output reg negative_flag,
  output reg halted,
  output reg irq
);
  // register state
  reg stop_pol_ff; // stop policy, 0 means continue
  reg [15:0] fatal_ff; // fatal flag word
  reg [15:0] task_log_ff; // task where operation stopped
  reg [ADDR_W-1:0] addr_log_ff; // program address at stop
  reg [`IEC_IRQ_W-1:0] mask_ff; // interrupt mask
  wire [`IEC_IRQ_W-1:0] stat_w; // sticky interrupt status
  wire not_bcd; // pointer word failed the bcd test
  reg [31:0] nxt_rdata; // read mux result
  // apb strobes; a write lands only at the edge where pready is seen
  // high, so the master and the slave agree on the moment it happens
  wire acc_phase = psel & penable & ~pready;
  wire wr_en = psel & penable & pready & pwrite;
  wire rd_en = acc_phase & ~pwrite;
  wire clr_cmd = wr_en & (paddr == `IEC_OFF_CTRL) &
    pwdata[`IEC_CTRL_CLEAR];

  iec_bcd_check u_bcd
  (
    .word_in(pointer_word),
    .not_bcd(not_bcd)
  );

  // instruction error causes; nothing executes once halted
  wire run = exec_done & ~halted;
  wire instr_err = run & (operand_bad | ~task_active);
  // access error causes, all gathered while the instruction runs
  wire acc_err = run & (acc_param_area |
    (acc_write & (acc_unmounted | acc_em_file | acc_read_only)) |
    (bcd_indirect & not_bcd));
  wire em_err = run & em_direct &
    (em_word_addr > `IEC_EM_MAX_WORD);
  wire bin_err = run & binary_indirect_mode &
    pointer_word[15];
  wire ir_err = run & ir_used & (ir_holds_bit ^ ir_used_as_bit);
  wire any_acc = acc_err | em_err | bin_err | ir_err;
  // fetch faults halt regardless of policy
  wire ill_op = fetch_valid & ~halted & fetch_opcode_bad;
  wire um_ovf = fetch_valid & ~halted & (fetch_addr > UM_LAST);
  wire stop_instr = instr_err & stop_pol_ff;
  wire stop_acc = any_acc & stop_pol_ff;
  wire fatal_now = stop_instr | stop_acc | ill_op | um_ovf;
  // the address that caused the stop, fetch faults take priority
  wire [ADDR_W-1:0] stop_addr = (ill_op | um_ovf) ? fetch_addr : exec_addr;

  // policy register; the reset value selects continue
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      stop_pol_ff <= 1'b0;
    else if (wr_en & (paddr == `IEC_OFF_CTRL))
      stop_pol_ff <= pwdata[`IEC_CTRL_STOP];
  end

  // instruction error flag and condition flags
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      instr_error_flag <= 1'b0;
      equality_flag <= 1'b0;
      negative_flag <= 1'b0;
    end
    else if (instr_err)
    begin
      // instruction suppressed, its results never written
      instr_error_flag <= 1'b1;
      if (flags_clear_on_err)
      begin
        equality_flag <= 1'b0;
        negative_flag <= 1'b0;
      end
    end
    else if (run)
    begin
      // an access error clears the error flag like any non-input completion
      if (~exec_is_input)
        instr_error_flag <= 1'b0;
      equality_flag <= eq_result;
      negative_flag <= neg_result;
    end
  end

  // access flag: only reset or software clear drops it, not task end
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      access_error_flag <= 1'b0;
    else if (any_acc)
      access_error_flag <= 1'b1;
    else if (clr_cmd)
      access_error_flag <= 1'b0;
  end

  // halt latch, fatal word and stop logs
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      halted <= 1'b0;
      fatal_ff <= 16'h0000;
      task_log_ff <= 16'h0000;
      addr_log_ff <= {ADDR_W{1'b0}};
    end
    else if (fatal_now)
    begin
      halted <= 1'b1;
      if (stop_instr)
        fatal_ff[`IEC_FAT_INSTR] <= 1'b1;
      if (stop_acc)
        fatal_ff[`IEC_FAT_ACCESS] <= 1'b1;
      if (ill_op)
        fatal_ff[`IEC_FAT_ILLEGAL] <= 1'b1;
      if (um_ovf)
        fatal_ff[`IEC_FAT_UMOVF] <= 1'b1;
      // interrupt tasks carry the top bit, cyclic tasks only 5 bits
      if (task_is_int)
        task_log_ff <= `IEC_TASK_INT_BASE | {8'h00, task_num};
      else
        task_log_ff <= {8'h00, task_num & `IEC_TASK_CYC_MAX};
      addr_log_ff <= stop_addr;
    end
    else if (clr_cmd)
    begin
      // explicit clear releases the halt; logs are kept for diagnosis
      halted <= 1'b0;
      fatal_ff <= 16'h0000;
    end
  end

  // one sticky bit per event class, write one to clear
  wire [`IEC_IRQ_W-1:0] evt_w = {fatal_now, any_acc, instr_err};
  genvar gi;
  generate
    for (gi = 0; gi < `IEC_IRQ_W; gi = gi + 1)
    begin : g_stat
      iec_sticky u_st
      (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .set_evt(evt_w[gi]),
        .clr_req(wr_en & (paddr == `IEC_OFF_IRQ_STAT) & pwdata[gi]),
        .bit_ff(stat_w[gi])
      );
    end
  endgenerate

  // mask register and registered interrupt output
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      mask_ff <= {`IEC_IRQ_W{1'b0}};
      irq <= 1'b0;
    end
    else
    begin
      if (wr_en & (paddr == `IEC_OFF_IRQ_MASK))
        mask_ff <= pwdata[`IEC_IRQ_W-1:0];
      irq <= |(stat_w & mask_ff);
    end
  end

  // read mux; unmapped addresses read zero, those above 01c also flag an error
  always @*
  begin
    nxt_rdata = 32'h0000_0000;
    if (paddr == `IEC_OFF_CTRL)
      nxt_rdata[`IEC_CTRL_STOP] = stop_pol_ff;
    else if (paddr == `IEC_OFF_FLAGS)
      nxt_rdata[4:0] = {halted, negative_flag, equality_flag,
        access_error_flag, instr_error_flag};
    else if (paddr == `IEC_OFF_FATAL)
      nxt_rdata[15:0] = fatal_ff;
    else if (paddr == `IEC_OFF_IRQ_STAT)
      nxt_rdata[`IEC_IRQ_W-1:0] = stat_w;
    else if (paddr == `IEC_OFF_IRQ_MASK)
      nxt_rdata[`IEC_IRQ_W-1:0] = mask_ff;
    else if (paddr == `IEC_OFF_TASK_LOG)
      nxt_rdata[15:0] = task_log_ff;
    else if (paddr == `IEC_OFF_ADDR_LO)
      nxt_rdata[15:0] = addr_log_ff[15:0];
    else if (paddr == `IEC_OFF_ADDR_HI)
      nxt_rdata[15:0] = addr_log_ff[31:16];
  end

  // apb answer: pready one cycle after the access phase starts
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= acc_phase;
      pslverr <= acc_phase & (paddr > `IEC_OFF_ADDR_HI);
      if (rd_en)
        prdata <= nxt_rdata;
    end
  end
endmodule // iec_error_check

// [testbench/iec_error_check_chk.sv]
// checker of the error checker's flag and halt behaviour
`timescale 1ns/1ps
module iec_error_check_chk
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic fetch_valid,
  input wire logic fetch_opcode_bad,
  input wire logic exec_done,
  input wire logic exec_is_input,
  input wire logic task_active,
  input wire logic operand_bad,
  input wire logic acc_param_area,
  input wire logic em_direct,
  input wire logic [15:0] em_word_addr,
  input wire logic binary_indirect_mode,
  input wire logic [15:0] pointer_word,
  input wire logic instr_error_flag,
  input wire logic access_error_flag,
  input wire logic halted
);
  // one clock domain, so clock and reset are given once
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // an instruction taken while running
  wire logic go = exec_done && !halted;
  // software clear through the control word
  wire logic clrw = psel && penable && pwrite && paddr == 12'h000
    && pwdata[1];
  a_bad_operand: assert property (go && operand_bad |=> instr_error_flag)
    else $error("bad operand left error flag low");
  a_no_task: assert property (go && !task_active |=> instr_error_flag)
    else $error("run without task left error flag low");
  a_clean_clear: assert property (go && task_active && !operand_bad
    && !exec_is_input |=> !instr_error_flag)
    else $error("clean completion kept error flag");
  a_param_access: assert property (go && acc_param_area
    |=> access_error_flag) else $error("parameter access not flagged");
  a_em_limit: assert property (go && em_direct
    && em_word_addr > 16'd32767 |=> access_error_flag)
    else $error("extended word limit not flagged");
  a_bin_pointer: assert property (go && binary_indirect_mode
    && pointer_word >= 16'h8000 |=> access_error_flag)
    else $error("binary pointer range not flagged");
  a_access_sticky: assert property (access_error_flag && !clrw
    |=> access_error_flag) else $error("access flag dropped by itself");
  a_opcode_halt: assert property (fetch_valid && fetch_opcode_bad
    && !halted |=> halted) else $error("undefined opcode did not halt");
  a_halt_holds: assert property (halted && !clrw |=> halted)
    else $error("halt released without clear");
endmodule // iec_error_check_chk

bind iec_error_check iec_error_check_chk iec_error_check_chk_inst (.*);

// [testbench/iec_seq_model.sv]
// sequencer and operand address model feeding the error checker
`timescale 1ns/1ps
module iec_seq_model
(
  input wire logic ref_clk,
  output logic fetch_valid,
  output logic [31:0] fetch_addr,
  output logic fetch_opcode_bad,
  output logic exec_done,
  output logic exec_is_input,
  output logic task_active,
  output logic task_is_int,
  output logic [7:0] task_num,
  output logic [31:0] exec_addr,
  output logic operand_bad,
  output logic flags_clear_on_err,
  output logic eq_result,
  output logic neg_result,
  output logic acc_param_area,
  output logic acc_write,
  output logic acc_unmounted,
  output logic acc_em_file,
  output logic acc_read_only,
  output logic bcd_indirect,
  output logic [15:0] pointer_word,
  output logic em_direct,
  output logic [15:0] em_word_addr,
  output logic binary_indirect_mode,
  output logic ir_used,
  output logic ir_holds_bit,
  output logic ir_used_as_bit
);
  // quiet bus between pulses: every qualifier back to a harmless level
  task automatic idle;
    {fetch_valid, fetch_addr, fetch_opcode_bad, exec_done, exec_is_input,
      task_is_int, task_num, exec_addr, operand_bad, flags_clear_on_err,
      eq_result, neg_result, acc_param_area, acc_write, acc_unmounted,
      acc_em_file, acc_read_only, bcd_indirect, pointer_word, em_direct,
      em_word_addr, binary_indirect_mode, ir_used, ir_holds_bit,
      ir_used_as_bit} <= '0;
    task_active <= 1'b1;
  endtask
  initial idle;
  // condition results and error policy of the next instruction only
  task automatic cond(input logic e, input logic n, input logic c);
    {eq_result, neg_result, flags_clear_on_err} <= {e, n, c};
  endtask
  // one finished instruction; k picks the access fault, 15 means no task
  task automatic run(input logic [3:0] k, input logic bad,
    input logic [8:0] t);
    exec_done <= 1'b1;
    operand_bad <= bad;
    task_active <= k != 4'hf;
    {task_is_int, task_num} <= t;
    exec_addr <= 32'h0001_1234;
    case (k)
      1: acc_param_area <= 1'b1;
      2: {acc_write, acc_unmounted} <= 2'b11;
      3: {acc_write, acc_em_file} <= 2'b11;
      4: {acc_write, acc_read_only} <= 2'b11;
      5: {bcd_indirect, pointer_word} <= {1'b1, 16'ha000};
      6: {em_direct, em_word_addr} <= {1'b1, 16'h8000};
      7: {binary_indirect_mode, pointer_word} <= {1'b1, 16'h8000};
      8: {ir_used, ir_holds_bit} <= 2'b11;
      9: {ir_used, ir_used_as_bit} <= 2'b11;
      default: ;
    endcase
    @(posedge ref_clk);
    idle;
  endtask
  // one instruction fetch, held for a single edge
  task automatic fetch(input logic [31:0] a, input logic bad);
    {fetch_valid, fetch_addr, fetch_opcode_bad} <= {1'b1, a, bad};
    @(posedge ref_clk);
    idle;
  endtask
endmodule // iec_seq_model

// [testbench/iec_error_check_bench.sv]
// self-checking bench of the error checker over apb
`timescale 1ns/1ps
`include "iec_regs.vh"
module iec_error_check_bench;
  logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, fetch_addr, exec_addr;
  logic fetch_valid, fetch_opcode_bad, exec_done, exec_is_input;
  logic task_active, task_is_int, operand_bad, flags_clear_on_err;
  logic eq_result, neg_result, acc_param_area, acc_write, acc_unmounted;
  logic acc_em_file, acc_read_only, bcd_indirect, em_direct, ir_used;
  logic binary_indirect_mode, ir_holds_bit, ir_used_as_bit, irq, halted;
  logic instr_error_flag, access_error_flag, equality_flag, negative_flag;
  logic [7:0] task_num;
  logic [15:0] pointer_word, em_word_addr;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  // small program area keeps the overflow address short
  iec_error_check #(.UM_LAST(32'h0000_00ff)) iec_error_check_inst (.*);
  iec_seq_model iec_seq_model_inst (.*);
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      report_and_stop;
    end
  end
  task automatic report_and_stop;
    if (err_total == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // apb cycle; entered just after an edge, request held until pready
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 50);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    xfer(1'b0, a, 32'h0, q, e);
    cmp($sformatf("reg %h", a), q, x);
  endtask
  // irq lags its status bit, so let the level settle first
  task automatic ci(input logic x);
    repeat (4) @(posedge ref_clk);
    cmp("irq", {31'h0, irq}, {31'h0, x});
  endtask
  initial
  begin
    logic [31:0] q;
    logic e;
    {psel, penable, pwrite, paddr, pwdata, sys_rst} <= '0 | 1'b1;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rc(`IEC_OFF_CTRL, 32'h0);
    iec_seq_model_inst.run(0, 1, 0); rc(`IEC_OFF_FLAGS, 32'h1);
    iec_seq_model_inst.run(0, 0, 0); rc(`IEC_OFF_FLAGS, 32'h0);
    iec_seq_model_inst.run(15, 0, 0); rc(`IEC_OFF_FLAGS, 32'h1);
    // every access fault alone: access flag up, error flag cleared
    for (int k = 1; k < 10; k++)
    begin
      wr(`IEC_OFF_CTRL, 32'h2);
      iec_seq_model_inst.run(k, 0, 0);
      rc(`IEC_OFF_FLAGS, 32'h2);
    end
    iec_seq_model_inst.run(0, 0, 9'h105);
    rc(`IEC_OFF_FLAGS, 32'h2);
    // condition flags: written on success, held or cleared on error
    iec_seq_model_inst.cond(1, 1, 0); iec_seq_model_inst.run(0, 0, 0);
    rc(`IEC_OFF_FLAGS, 32'he);
    iec_seq_model_inst.run(0, 1, 0);
    rc(`IEC_OFF_FLAGS, 32'hf);
    iec_seq_model_inst.cond(1, 1, 1); iec_seq_model_inst.run(0, 1, 0);
    rc(`IEC_OFF_FLAGS, 32'h3);
    wr(`IEC_OFF_IRQ_MASK, 32'h1); wr(`IEC_OFF_IRQ_STAT, 32'h7); ci(0);
    iec_seq_model_inst.run(0, 1, 0); ci(1);
    wr(`IEC_OFF_IRQ_STAT, 32'h1); ci(0);
    wr(`IEC_OFF_IRQ_MASK, 32'h0); iec_seq_model_inst.run(0, 1, 0); ci(0);
    rc(`IEC_OFF_IRQ_STAT, 32'h1);
    // stop policy: instruction error from interrupt task 255
    wr(`IEC_OFF_CTRL, 32'h3); iec_seq_model_inst.run(0, 1, 9'h1ff);
    rc(`IEC_OFF_FATAL, 32'h100);
    rc(`IEC_OFF_TASK_LOG, 32'h80ff);
    rc(`IEC_OFF_ADDR_LO, 32'h1234);
    rc(`IEC_OFF_ADDR_HI, 32'h1);
    iec_seq_model_inst.run(1, 0, 0); rc(`IEC_OFF_FLAGS, 32'h11);
    wr(`IEC_OFF_CTRL, 32'h3); rc(`IEC_OFF_FATAL, 32'h0);
    iec_seq_model_inst.run(1, 0, 9'h03f);
    rc(`IEC_OFF_FATAL, 32'h400);
    rc(`IEC_OFF_TASK_LOG, 32'h1f);
    // fetch faults halt even under the continue policy
    wr(`IEC_OFF_CTRL, 32'h2); iec_seq_model_inst.fetch(32'h10, 1);
    rc(`IEC_OFF_FATAL, 32'h4000);
    wr(`IEC_OFF_CTRL, 32'h2); iec_seq_model_inst.fetch(32'h100, 0);
    rc(`IEC_OFF_FATAL, 32'h8000);
    xfer(1'b0, 12'h020, 32'h0, q, e);
    cmp("unmapped error", {31'h0, e}, 32'h1);
    cmp("unmapped data", q, 32'h0);
    report_and_stop;
  end
endmodule // iec_error_check_bench
